// >>> ddrcr_map.svh
// Register offsets, field positions and reset values of the DDR2 configuration and refresh block.
// Assumes a byte-addressed register port with one aligned 32-bit word per register.
`ifndef DDRCR_MAP_SVH
`define DDRCR_MAP_SVH

// Register offsets
`define DDRCR_ADDR_CONFIG 8'h08
`define DDRCR_ADDR_REFRESH 8'h0C
`define DDRCR_ADDR_TIMING1 8'h10
`define DDRCR_ADDR_TIMING2 8'h14

// Configuration register fields
`define DDRCR_CFG_UNLOCK_BIT 15
`define DDRCR_CFG_CAS_MSB 11
`define DDRCR_CFG_CAS_LSB 9
`define DDRCR_CFG_BANK_MSB 6
`define DDRCR_CFG_BANK_LSB 4
`define DDRCR_CFG_PAGE_MSB 2
`define DDRCR_CFG_PAGE_LSB 0

// Refresh control register fields
`define DDRCR_RFC_SR_BIT 31
`define DDRCR_RFC_RATE_MSB 15
`define DDRCR_RFC_RATE_LSB 0
`define DDRCR_RFC_BIT30_VAL 1'h0

// First timing register refresh-cycle field and write mask
`define DDRCR_TIM1_RFC_MSB 31
`define DDRCR_TIM1_RFC_LSB 25
`define DDRCR_TIM1_MASK 32'hFFFFFFFB

// Reset values
`define DDRCR_RST_UNLOCK 1'h0
`define DDRCR_RST_CAS 3'h5
`define DDRCR_RST_BANK 3'h2
`define DDRCR_RST_PAGE 3'h0
`define DDRCR_RST_RATE 16'h0400
`define DDRCR_RST_TIM1 32'h7FFFFFFB
`define DDRCR_RST_TIM2 32'h00000000
`define DDRCR_RST_BANK_COUNT 4'h4

// Decode limits and refresh floor
`define DDRCR_CAS_MIN 3'h2
`define DDRCR_CAS_MAX 3'h5
`define DDRCR_BANK_MAX 3'h3
`define DDRCR_PAGE_MAX 3'h3
`define DDRCR_COLUMN_BASE 4'h8
`define DDRCR_BANK_ONE 4'h1
`define DDRCR_RATE_MIN 16'h0100
`define DDRCR_RFC_SHIFT 1
`define DDRCR_RATE_STEP 16'h0001

`endif

// >>> ddrcr_pkg.sv
// Types shared by the DDR2 configuration and refresh block.
// Assumes ddrcr_map.svh supplies offsets and reset values.
`default_nettype none

package ddrcr_pkg;
  // Data word of the register port
  typedef logic [31:0] ddrcr_word_t;
  // Refresh interval in memory clocks
  typedef logic [15:0] ddrcr_rate_t;
  // Three-bit configuration code
  typedef logic [2:0] ddrcr_code_t;
  // Self-refresh state
  typedef enum logic [0:0] {
    SR_NORMAL = 1'b0,
    SR_ACTIVE = 1'b1
  } ddrcr_sr_t;
  // Whole state of the register and self-refresh logic
  typedef struct packed {
    logic unlock;
    ddrcr_code_t cas;
    ddrcr_code_t bank;
    ddrcr_code_t page;
    logic srReq;
    ddrcr_sr_t srState;
    ddrcr_rate_t rate;
    ddrcr_word_t timing1;
    ddrcr_word_t timing2;
    ddrcr_word_t rdData;
    logic initStart;
    logic srEnter;
    logic srExit;
    logic [3:0] bankCount;
    logic [3:0] columnBits;
    logic configLegal;
  } ddrcr_state_t;
  // Whole state of the refresh interval timer
  typedef struct packed {
    ddrcr_rate_t count;
    logic tick;
  } ddrcr_timer_t;
endpackage : ddrcr_pkg

`default_nettype wire

// >>> ddrcr_refresh_timer.sv
// Auto-refresh interval timer: one tick every interval memory clocks.
// Assumes reload and enable come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "ddrcr_map.svh"

module ddrcr_refresh_timer (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Control
  input wire ddrcr_pkg::ddrcr_rate_t interval,
  input wire logic reload,
  input wire logic enable,
  // Refresh request pulse
  output logic tick
);
  import ddrcr_pkg::*;

  ddrcr_timer_t s; // Registered state
  ddrcr_timer_t next_s; // Next state

  // Countdown; reload wins so a new interval starts cleanly
  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    if (reload) begin
      next_s.count = interval - `DDRCR_RATE_STEP; // R15
    end else if (enable) begin
      // Held while in self-refresh, no ticks there
      if (s.count == '0) begin
        next_s.tick = 1'b1; // R11
        next_s.count = interval - `DDRCR_RATE_STEP; // R11
      end else begin
        next_s.count = s.count - `DDRCR_RATE_STEP;
      end
    end
  end

  // State register
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      s.count <= `DDRCR_RST_RATE - `DDRCR_RATE_STEP;
      s.tick <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  assign tick = s.tick;

  // A reload never lets a stale tick through next cycle
  reload_quiet_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // R15
    reload |=> !tick)
    else $error("tick right after reload");

  // Held timer gives no tick
  hold_quiet_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // R15
    !enable && !reload |=> !tick)
    else $error("tick while timer held");
endmodule : ddrcr_refresh_timer

`default_nettype wire

// >>> ddrcr_config_refresh.sv
// Configuration and refresh control of the DDR2 memory controller.
// Holds CAS latency, bank count and page size, the timing registers,
// self-refresh request and the auto-refresh interval.
// Assumes a same-clock register master: one-cycle strobes, read data next cycle.
`timescale 1ns/1ps
`default_nettype none
`include "ddrcr_map.svh"

// Contract
// R1: CAS latency field drives memory latency
// R2: CAS latency write starts initialization
// R3: CAS latency writable only while unlocked
// R4: Bank field codes one, two, four, eight
// R5: Bank field write starts initialization
// R6: Page field gives 8 to 11 columns
// R7: Page field write starts initialization
// R8: Reserved bits read zero, writes ignored
// R9: Self-refresh bit enters and leaves self-refresh
// R10: Software keeps refresh bit 30 default
// R11: One auto-refresh every interval clocks
// R12: Interval below floor loads twice cycle time
// R13: Unlock gates timing writes, starts initialization
// R14: Timing field holds refresh cycle time
// R15: Interval write restarts counter; none in self-refresh
module ddrcr_config_refresh #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Register port
  input wire logic [ADDR_W-1:0] regAddr,
  input wire ddrcr_pkg::ddrcr_word_t regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output ddrcr_pkg::ddrcr_word_t regRdData,
  // Memory geometry and latency
  output ddrcr_pkg::ddrcr_code_t casLatency,
  output logic [3:0] bankCount,
  output logic [3:0] columnBits,
  output logic configLegal,
  // Timing register contents for the command path
  output ddrcr_pkg::ddrcr_word_t firstTiming,
  output ddrcr_pkg::ddrcr_word_t secondTiming,
  // Initialization trigger
  output logic initStart,
  // Refresh control
  output logic selfRefreshActive,
  output logic selfRefreshEnter,
  output logic selfRefreshExit,
  output logic autoRefreshReq
);
  import ddrcr_pkg::*;

  // Address decode needs room for the highest offset
  if (ADDR_W < 8) begin : gAddrCheck
    $error("ADDR_W too narrow for the register map");
  end

  ddrcr_state_t s; // Registered state
  ddrcr_state_t next_s; // Next state

  logic hitConfig; // Address selects configuration
  logic hitRefresh; // Address selects refresh control
  logic hitTiming1; // Address selects first timing register
  logic hitTiming2; // Address selects second timing register
  logic rateWrite; // Refresh control written this cycle
  logic [6:0] rfcField; // Refresh cycle time in clocks
  ddrcr_rate_t floorRate; // Substitute for a too-small interval
  ddrcr_rate_t wrRate; // Interval field of the write data
  logic timerEnable; // Timer runs outside self-refresh
  logic timerReload; // Timer restarts from the next interval value
  logic timerTick; // One auto-refresh request

  // Address decode, chained so at most one register is hit
  always_comb begin
    hitConfig = 1'b0;
    hitRefresh = 1'b0;
    hitTiming1 = 1'b0;
    hitTiming2 = 1'b0;
    if (regAddr == ADDR_W'(`DDRCR_ADDR_CONFIG)) begin
      hitConfig = 1'b1;
    end else if (regAddr == ADDR_W'(`DDRCR_ADDR_REFRESH)) begin
      hitRefresh = 1'b1;
    end else if (regAddr == ADDR_W'(`DDRCR_ADDR_TIMING1)) begin
      hitTiming1 = 1'b1;
    end else if (regAddr == ADDR_W'(`DDRCR_ADDR_TIMING2)) begin
      hitTiming2 = 1'b1;
    end
  end

  // Refresh cycle time sits in the top of the first timing register
  assign rfcField = s.timing1[`DDRCR_TIM1_RFC_MSB:`DDRCR_TIM1_RFC_LSB]; // R14
  // Twice the cycle time; a zero cycle time gives a zero interval
  assign floorRate = ddrcr_rate_t'(rfcField) << `DDRCR_RFC_SHIFT; // R12
  assign wrRate = regWrData[`DDRCR_RFC_RATE_MSB:`DDRCR_RFC_RATE_LSB];
  assign rateWrite = regWrite && hitRefresh;

  // Register writes, reads, decode and self-refresh sequencing
  always_comb begin
    next_s = s;
    // Pulses last one cycle
    next_s.initStart = 1'b0;
    next_s.srEnter = 1'b0;
    next_s.srExit = 1'b0;
    // Read data stands only in the cycle after the strobe
    next_s.rdData = '0;

    // Write side
    if (regWrite && hitConfig) begin
      // Unlock bit itself is always writable
      next_s.unlock = regWrData[`DDRCR_CFG_UNLOCK_BIT]; // R13
      if (s.unlock) begin
        // Locked writes leave the latency as it was
        next_s.cas = regWrData[`DDRCR_CFG_CAS_MSB:`DDRCR_CFG_CAS_LSB]; // R3
      end
      next_s.bank = regWrData[`DDRCR_CFG_BANK_MSB:`DDRCR_CFG_BANK_LSB]; // R4
      next_s.page = regWrData[`DDRCR_CFG_PAGE_MSB:`DDRCR_CFG_PAGE_LSB]; // R6
      // Every write touches bank, page and the unlock bit; the latency only while unlocked
      next_s.initStart = 1'b1; // R2 R5 R7 R13
    end else if (rateWrite) begin
      next_s.srReq = regWrData[`DDRCR_RFC_SR_BIT]; // R9
      // Too small an interval would starve the command path
      if (wrRate < `DDRCR_RATE_MIN) begin
        next_s.rate = floorRate; // R12
      end else begin
        next_s.rate = wrRate; // R11
      end
    end else if (regWrite && hitTiming1 && s.unlock) begin
      // Reserved bit stays zero
      next_s.timing1 = regWrData & `DDRCR_TIM1_MASK; // R13
    end else if (regWrite && hitTiming2 && s.unlock) begin
      next_s.timing2 = regWrData; // R13
    end

    // Read side; unlisted bits and unmapped offsets read zero
    if (regRead) begin
      if (hitConfig) begin
        next_s.rdData[`DDRCR_CFG_UNLOCK_BIT] = s.unlock;
        next_s.rdData[`DDRCR_CFG_CAS_MSB:`DDRCR_CFG_CAS_LSB] = s.cas; // R8
        next_s.rdData[`DDRCR_CFG_BANK_MSB:`DDRCR_CFG_BANK_LSB] = s.bank; // R8
        next_s.rdData[`DDRCR_CFG_PAGE_MSB:`DDRCR_CFG_PAGE_LSB] = s.page; // R8
      end else if (hitRefresh) begin
        next_s.rdData[`DDRCR_RFC_SR_BIT] = s.srReq;
        // Bit 30 reads its default so a read-modify-write keeps it
        next_s.rdData[`DDRCR_RFC_SR_BIT-1] = `DDRCR_RFC_BIT30_VAL; // R10
        next_s.rdData[`DDRCR_RFC_RATE_MSB:`DDRCR_RFC_RATE_LSB] = s.rate; // R8
      end else if (hitTiming1) begin
        next_s.rdData = s.timing1;
      end else if (hitTiming2) begin
        next_s.rdData = s.timing2;
      end
    end

    // Self-refresh follows the stored request one cycle later
    case (s.srState)
      SR_NORMAL: begin
        if (s.srReq) begin
          next_s.srState = SR_ACTIVE; // R9
          next_s.srEnter = 1'b1; // R9
        end
      end
      SR_ACTIVE: begin
        if (!s.srReq) begin
          next_s.srState = SR_NORMAL; // R9
          next_s.srExit = 1'b1; // R9
        end
      end
      default: begin
        next_s.srState = SR_NORMAL;
      end
    endcase

    // Geometry decode, registered so the outputs come from flops
    next_s.bankCount = 4'(`DDRCR_BANK_ONE << next_s.bank[1:0]); // R4
    next_s.columnBits = 4'(`DDRCR_COLUMN_BASE + {1'b0, next_s.page}); // R6
    // Reserved codes are stored but flagged
    next_s.configLegal = (next_s.cas >= `DDRCR_CAS_MIN) && (next_s.cas <= `DDRCR_CAS_MAX)
      && (next_s.bank <= `DDRCR_BANK_MAX) && (next_s.page <= `DDRCR_PAGE_MAX); // R1
  end

  // State register
  // Reset values of the decoded outputs match the decode of the reset codes
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      s.unlock <= `DDRCR_RST_UNLOCK;
      s.cas <= `DDRCR_RST_CAS;
      s.bank <= `DDRCR_RST_BANK;
      s.page <= `DDRCR_RST_PAGE;
      s.srReq <= 1'b0;
      s.srState <= SR_NORMAL;
      s.rate <= `DDRCR_RST_RATE;
      s.timing1 <= `DDRCR_RST_TIM1;
      s.timing2 <= `DDRCR_RST_TIM2;
      s.rdData <= '0;
      s.initStart <= 1'b0;
      s.srEnter <= 1'b0;
      s.srExit <= 1'b0;
      s.bankCount <= `DDRCR_RST_BANK_COUNT;
      s.columnBits <= `DDRCR_COLUMN_BASE;
      s.configLegal <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // Timer restarts on an interval write and on leaving self-refresh
  // Leaving costs one extra cycle: the reload follows the exit pulse
  assign timerReload = rateWrite || s.srExit; // R15
  // No auto-refresh while the memory refreshes itself
  assign timerEnable = (s.srState == SR_NORMAL); // R15

  // Interval counter
  // Fed the next interval so a write reloads with the value it stores
  ddrcr_refresh_timer uTimer (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .interval(next_s.rate),
    .reload(timerReload),
    .enable(timerEnable),
    .tick(timerTick)
  );

  // Outputs straight from flops
  assign regRdData = s.rdData;
  assign casLatency = s.cas; // R1
  assign bankCount = s.bankCount;
  assign columnBits = s.columnBits;
  assign configLegal = s.configLegal;
  assign firstTiming = s.timing1;
  assign secondTiming = s.timing2;
  assign initStart = s.initStart;
  assign selfRefreshActive = (s.srState == SR_ACTIVE);
  assign selfRefreshEnter = s.srEnter;
  assign selfRefreshExit = s.srExit;
  assign autoRefreshReq = timerTick;

  // Any configuration write starts initialization next cycle
  cfg_init_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // R2
    regWrite && hitConfig |=> initStart)
    else $error("config write without init pulse");

  // No initialization pulse without a configuration write
  init_only_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // R13
    !(regWrite && hitConfig) |=> !initStart)
    else $error("init pulse without config write");

  // Locked latency field stays put
  cas_lock_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // R3
    regWrite && hitConfig && !s.unlock |=> $stable(casLatency))
    else $error("latency changed while locked");

  // Unlocked latency write takes the written code
  cas_take_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // R1
    regWrite && hitConfig && s.unlock
    |=> casLatency == $past(regWrData[`DDRCR_CFG_CAS_MSB:`DDRCR_CFG_CAS_LSB]))
    else $error("latency write lost");

  // Code three means eight banks
  bank_eight_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // R4
    regWrite && hitConfig && regWrData[`DDRCR_CFG_BANK_MSB:`DDRCR_CFG_BANK_LSB] == 3'h3
    |=> bankCount == 4'h8)
    else $error("bank decode wrong");

  // Page code three means eleven column bits
  col_eleven_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // R6
    regWrite && hitConfig && regWrData[`DDRCR_CFG_PAGE_MSB:`DDRCR_CFG_PAGE_LSB] == 3'h3
    |=> columnBits == 4'hB)
    else $error("column decode wrong");

  // Reserved configuration bits 31:16, 8:7 and 3 read zero
  rsv_read_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // R8
    regRead && hitConfig |=> regRdData[8:7] == 2'h0 && !regRdData[3]
      && regRdData[31:16] == 16'h0000)
    else $error("reserved config bits not zero");

  // Self-refresh entered two cycles after the request write
  sr_enter_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // R9
    regWrite && hitRefresh && regWrData[`DDRCR_RFC_SR_BIT] && !selfRefreshActive && !s.srReq
    |=> ##1 selfRefreshActive && selfRefreshEnter)
    else $error("self-refresh not entered");

  // Small interval replaced by twice the cycle time
  rate_floor_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // R12
    rateWrite && wrRate < `DDRCR_RATE_MIN |=> s.rate == $past(floorRate))
    else $error("interval floor not applied");

  // No auto-refresh once self-refresh has settled
  sr_quiet_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // R15
    selfRefreshActive && $past(selfRefreshActive) |-> !autoRefreshReq)
    else $error("auto-refresh during self-refresh");

  // Locked first timing register stays put
  tim1_lock_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // R13
    regWrite && hitTiming1 && !s.unlock |=> $stable(firstTiming))
    else $error("timing 1 changed while locked");

  // Locked second timing register stays put
  tim2_lock_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // R13
    regWrite && hitTiming2 && !s.unlock |=> $stable(secondTiming))
    else $error("timing 2 changed while locked");

  // Unlocked first timing write lands, reserved bit cleared
  tim1_take_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // R14
    regWrite && hitTiming1 && s.unlock
    |=> firstTiming == ($past(regWrData) & `DDRCR_TIM1_MASK))
    else $error("timing 1 write lost");

  // Reserved refresh control bits read zero
  rsv_refresh_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // R8
    regRead && hitRefresh |=> regRdData[29:16] == 14'h0000 && !regRdData[30])
    else $error("reserved refresh bits not zero");

  // Read data stand only after a read strobe
  rd_idle_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // R8
    !regRead |=> regRdData == 32'h00000000)
    else $error("read data outside read cycle");

  // Self-refresh left two cycles after the clearing write
  sr_exit_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // R9
    regWrite && hitRefresh && !regWrData[`DDRCR_RFC_SR_BIT] && selfRefreshActive && s.srReq
    |=> ##1 !selfRefreshActive && selfRefreshExit)
    else $error("self-refresh not left");

  // Interval at or above the floor is stored as written
  rate_keep_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // R11
    rateWrite && wrRate >= `DDRCR_RATE_MIN |=> s.rate == $past(wrRate))
    else $error("interval write lost");

  // Entry and exit pulses agree with the state they announce
  sr_pulse_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // R9
    selfRefreshEnter || selfRefreshExit |-> selfRefreshActive == selfRefreshEnter)
    else $error("self-refresh pulse against state");

  // Code zero means one bank
  bank_one_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // R4
    regWrite && hitConfig && regWrData[`DDRCR_CFG_BANK_MSB:`DDRCR_CFG_BANK_LSB] == 3'h0
    |=> bankCount == 4'h1)
    else $error("single bank decode wrong");

  // Page code zero means eight column bits
  col_eight_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // R6
    regWrite && hitConfig && regWrData[`DDRCR_CFG_PAGE_MSB:`DDRCR_CFG_PAGE_LSB] == 3'h0
    |=> columnBits == 4'h8)
    else $error("short page decode wrong");
endmodule : ddrcr_config_refresh

`default_nettype wire

// >>> placeholder_end.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// >>> ddrcr_sdram_model.sv
// Behavioural model of the external DDR2 memory seen by the refresh logic.
// Assumes the controller's command pulses are one cycle wide on sys_clk.
`timescale 1ns/1ps
`default_nettype none

module ddrcr_sdram_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Commands from the controller
  input wire logic autoRefreshReq,
  input wire logic selfRefreshEnter,
  input wire logic selfRefreshExit,
  // Observed memory state
  output logic inSelfRefresh,
  output logic refreshInSr
);
  // Memory mode tracking; a refresh in self-refresh is illegal for the part
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      inSelfRefresh <= 1'b0;
      refreshInSr <= 1'b0;
    end else begin
      // Enter wins over exit, the controller never sends both
      if (selfRefreshEnter) begin
        inSelfRefresh <= 1'b1;
      end else if (selfRefreshExit) begin
        inSelfRefresh <= 1'b0;
      end
      // Sticky flag, so a single stray refresh is never missed
      if (autoRefreshReq && inSelfRefresh) begin
        refreshInSr <= 1'b1;
      end
    end
  end
endmodule : ddrcr_sdram_model

`default_nettype wire

// >>> tb_ddr2_config_refresh_ctrl.sv
// Self-checking bench of the configuration and refresh block.
// Assumes the register map header and package of the design are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "ddrcr_map.svh"

module tb_ddr2_config_refresh_ctrl;
  import ddrcr_pkg::*;
  // Bench clock, reset and register port
  logic sysClk, resetN, regWrite, regRead;
  logic [7:0] regAddr;
  ddrcr_word_t regWrData, regRdData, firstTiming, secondTiming, rdVal;
  // Design outputs
  ddrcr_code_t casLatency;
  logic [3:0] bankCount, columnBits;
  logic configLegal, initStart, srActive, srEnter, srExit, autoRefreshReq;
  // Memory model state
  logic inSelfRefresh, refreshInSr;
  int nFail, cmpCount, k;

  ddrcr_config_refresh #(.ADDR_W(8)) i_dut (
    .sys_clk(sysClk), .reset_n(resetN), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .casLatency(casLatency), .bankCount(bankCount), .columnBits(columnBits),
    .configLegal(configLegal), .firstTiming(firstTiming), .secondTiming(secondTiming),
    .initStart(initStart), .selfRefreshActive(srActive), .selfRefreshEnter(srEnter),
    .selfRefreshExit(srExit), .autoRefreshReq(autoRefreshReq));

  ddrcr_sdram_model i_mem (
    .sys_clk(sysClk), .reset_n(resetN), .autoRefreshReq(autoRefreshReq),
    .selfRefreshEnter(srEnter), .selfRefreshExit(srExit),
    .inSelfRefresh(inSelfRefresh), .refreshInSr(refreshInSr));

  // 40 MHz clock
  initial begin
    sysClk = 1'b0;
    forever #12.5 sysClk = ~sysClk;
  end

  // Compare one value and count it
  task automatic check(input logic [31:0] seen, input logic [31:0] expv);
    cmpCount++;
    if (seen !== expv) begin
      nFail++;
      $display("FAIL %0t seen %h expected %h", $time, seen, expv);
    end
  endtask : check

  // One-cycle write; returns just after the edge that took it
  task automatic wr(input logic [7:0] a, input ddrcr_word_t d);
    @(posedge sysClk);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge sysClk);
    regWrite <= 1'b0;
    #1;
  endtask : wr

  // One-cycle read; data stand only in the following cycle
  task automatic rd(input logic [7:0] a, output ddrcr_word_t d);
    @(posedge sysClk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge sysClk);
    regRead <= 1'b0;
    #1;
    d = regRdData;
  endtask : rd

  // Cycles until the next refresh pulse, bounded so a dead timer cannot hang
  task automatic wait_tick(output int n);
    n = 0;
    do begin
      @(posedge sysClk);
      #1;
      n++;
    end while (autoRefreshReq !== 1'b1 && n < 70000);
  endtask : wait_tick

  // Single exit point of the run
  task automatic giveVerdict();
    if (nFail == 0 && cmpCount > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : giveVerdict

  // Watchdog; the sequence needs about 1430 cycles
  initial begin
    repeat (20000) @(posedge sysClk);
    nFail++;
    giveVerdict();
  end

  // Main sequence; bit 30 of every refresh write is kept at 0
  initial begin
    resetN = 1'b0;
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 8'h00;
    regWrData = 32'h00000000;
    nFail = 0;
    cmpCount = 0;
    repeat (5) @(posedge sysClk);
    resetN <= 1'b1;
    // Reset contents and unmapped space
    rd(`DDRCR_ADDR_CONFIG, rdVal);
    check(rdVal, 32'h00000A20);
    rd(`DDRCR_ADDR_REFRESH, rdVal);
    check(rdVal, 32'h00000400);
    rd(8'h40, rdVal);
    check(rdVal, 32'h00000000);
    check(firstTiming, 32'h7FFFFFFB);
    check(secondTiming, 32'h00000000);
    // Locked write: latency kept, others stored, reserved bits read zero
    wr(`DDRCR_ADDR_CONFIG, 32'hFFFFFFFF);
    check({31'h0, initStart}, 32'h1);
    check({29'h0, casLatency}, 32'h5);
    check({31'h0, configLegal}, 32'h0);
    rd(`DDRCR_ADDR_CONFIG, rdVal);
    check(rdVal, 32'h00008A77);
    // Unlocked writes through every legal code
    for (int i = 0; i < 4; i++) begin
      wr(`DDRCR_ADDR_CONFIG, 32'h8000 | (32'(i + 2) << 9) | (32'(i) << 4) | 32'(i));
      check({31'h0, initStart}, 32'h1);
      check({29'h0, casLatency}, 32'(i + 2));
      check({28'h0, bankCount}, 32'h1 << i);
      check({28'h0, columnBits}, 32'(8 + i));
      check({31'h0, configLegal}, 32'h1);
    end
    // Timing write while unlocked, then lock and retry
    // Reserved bit 2 of the first timing register is dropped
    wr(`DDRCR_ADDR_TIMING1, 32'h04000004);
    check(firstTiming, 32'h04000000);
    wr(`DDRCR_ADDR_TIMING2, 32'h12345678);
    check(secondTiming, 32'h12345678);
    wr(`DDRCR_ADDR_CONFIG, 32'h00000A20);
    check({31'h0, initStart}, 32'h1);
    wr(`DDRCR_ADDR_TIMING1, 32'hFFFFFFF8);
    check(firstTiming, 32'h04000000);
    wr(`DDRCR_ADDR_TIMING2, 32'h00000000);
    check(secondTiming, 32'h12345678);
    rd(`DDRCR_ADDR_TIMING2, rdVal);
    check(rdVal, 32'h12345678);
    // Interval just below the floor takes twice the cycle time
    wr(`DDRCR_ADDR_REFRESH, 32'h000000FF);
    wait_tick(k);
    check(32'(k), 32'h4);
    wait_tick(k);
    check(32'(k), 32'h4);
    rd(`DDRCR_ADDR_REFRESH, rdVal);
    check(rdVal, 32'h00000004);
    // Interval at the floor is kept; counter restarts on write
    wr(`DDRCR_ADDR_REFRESH, 32'h00000100);
    wait_tick(k);
    check(32'(k), 32'h100);
    wait_tick(k);
    check(32'(k), 32'h100);
    // Self-refresh entry with reserved bits set
    wr(`DDRCR_ADDR_REFRESH, 32'hBFFF0100);
    repeat (1) @(posedge sysClk);
    #1;
    check({30'h0, srEnter, srActive}, 32'h3);
    rd(`DDRCR_ADDR_REFRESH, rdVal);
    check(rdVal, 32'h80000100);
    repeat (600) @(posedge sysClk);
    #1;
    check({30'h0, inSelfRefresh, refreshInSr}, 32'h2);
    // Exit, then refreshes resume one interval after the reload behind the exit pulse
    wr(`DDRCR_ADDR_REFRESH, 32'h00000100);
    repeat (1) @(posedge sysClk);
    #1;
    check({30'h0, srExit, srActive}, 32'h2);
    wait_tick(k);
    check(32'(k), 32'h101);
    check({31'h0, inSelfRefresh}, 32'h0);
    giveVerdict();
  end
endmodule : tb_ddr2_config_refresh_ctrl

`default_nettype wire
